// ---- design/rgl_reset_gen.sv ----
/*
 * Reset generator: APB registers, GPIO source select, long-press
 * decision and the power-on / hardware / software reset sequencer.
 * Assumes all inputs are synchronous to clk (25 MHz) and reset_n is
 * the supply monitor's synchronous active-low power-on reset.
 */
// Our own choices: the APB register port and the placing of the registers.
// How it works
// - three reset levels, power-on, hardware, software, each clearing its own registers
// - pad or enabled GPIO held for the programmed delay raises power-on reset
// - pad released before the delay gives only a hardware reset
// - pad held for the delay or longer gives power-on reset
// - software reset is reboot bit write OR processor reset request
// - wake-from-sleep gives hardware reset when the wake bit is set
// - power-on and hardware resets end in a cold boot start pulse
// - trim, polarity, timer setting registers cleared by power-on reset only
// - control, wake and oscillator enable, otp count, freeze and mapping cleared by power-on or hardware
// - all other registers cleared by any reset level, except cause, which each level only sets
// - reset pad is always active high and always a source
// - delay factor is a 7-bit field, at most 0x7f
// - delay is factor times 4096 slow oscillator periods
// - slow oscillator forced on while any source is asserted
// - pad-started press uses default oscillator trim, GPIO keeps programmed trim
// - the selected GPIO is only observed, still usable as a GPIO
// - pin field holds pin number, zero disables GPIO source
// - polarity bit zero means active low, one means active high
// - timer counts while a source asserts, zero on release
// - overlapping sources keep one continuous count
// - pin field cleared by every reset, factor by power-on reset
`timescale 1ns/1ps

module rgl_reset_gen
    import rgl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        resetPad,
    input  wire logic [31:0] gpioIn,
    input  wire logic        slowClkIn,
    input  wire logic        cpuSysResetReq,
    input  wire logic        wakeFromSleep,
    output logic             porResetOut,
    output logic             hwResetOut,
    output logic             swResetOut,
    output logic             coldBootStart,
    output logic             slowOscEnable,
    output logic             slowOscDefaultTrim,
    output logic      [15:0] referenceTrim,
    output logic      [15:0] radioTrim,
    output logic      [15:0] otpWordCount,
    output logic      [1:0]  exchangeMemMap,
    output logic             debugFreezeEn
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    rgl_timer_if tif ();

    rgl_factor_t                delayFactor;
    rgl_pin_t                   pinSelect;
    logic                       gpioPolarity;
    logic [15:0]                sysCtrl;
    logic                       wakeTriggersHw;
    logic                       slowOscSwEnable;
    logic [15:0]                scratch;
    logic [3:0]                 cause;
    logic                       slowPrev;
    logic                       padPrev;
    logic                       gpioActive;
    rgl_seq_t                   seqState;
    rgl_seq_t                   reqLevel;
    logic [`RGL_HOLD_W-1:0]     hold;
    logic                       take;
    logic                       clrPor;
    logic                       clrHw;
    logic                       clrAll;
    logic                       wrEn;
    logic                       rebootWrite;
    logic                       padRelease;
    logic                       hwReq;
    logic                       swReq;
    logic [31:0]                rdValue;

    function automatic logic addrMapped(input logic [7:0] a);
        unique case (a)
            `RGL_OFS_LPT, `RGL_OFS_PIN, `RGL_OFS_SYSCTRL, `RGL_OFS_PMU,
            `RGL_OFS_GENCTRL, `RGL_OFS_REFTRIM, `RGL_OFS_RADIOTRIM,
            `RGL_OFS_OTPWC, `RGL_OFS_SCRATCH, `RGL_OFS_STATUS,
            `RGL_OFS_CAUSE: addrMapped = 1'b1;
            default:        addrMapped = 1'b0;
        endcase
    endfunction : addrMapped

    ////////////////////////////////////////////////////////////////////////////////
    // sources and timer

    assign gpioActive = (pinSelect != `RGL_PIN_OFF) &&
                        (gpioIn[pinSelect] == gpioPolarity);

    assign tif.padActive   = resetPad;
    assign tif.gpioActive  = gpioActive;
    assign tif.slowTick    = slowClkIn & ~slowPrev;
    assign tif.delayFactor = delayFactor;

    rgl_long_press_timer u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .tif     (tif.timer)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slowPrev <= 1'b0;
            padPrev  <= 1'b0;
        end else begin
            slowPrev <= slowClkIn;
            padPrev  <= resetPad;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slowOscEnable      <= 1'b0;
            slowOscDefaultTrim <= 1'b0;
        end else begin
            slowOscEnable      <= slowOscSwEnable | resetPad | gpioActive;
            slowOscDefaultTrim <= tif.busy ? tif.padFirst : resetPad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset sequencer

    assign padRelease  = padPrev & ~resetPad;
    assign wrEn        = psel & penable & pwrite;
    assign rebootWrite = wrEn && (paddr == `RGL_OFS_SYSCTRL) && pwdata[`RGL_REBOOT_BIT];
    assign hwReq = (padRelease & ~tif.fired & ~tif.expire) | (wakeFromSleep & wakeTriggersHw);
    assign swReq = rebootWrite | cpuSysResetReq;

    always_comb begin
        if (tif.expire) begin
            reqLevel = SEQ_POR;
        end else if (hwReq) begin
            reqLevel = SEQ_HW;
        end else if (swReq) begin
            reqLevel = SEQ_SW;
        end else begin
            reqLevel = SEQ_IDLE;
        end
    end

    // a request at or above the running level restarts the hold
    assign take = (reqLevel != SEQ_IDLE) && (reqLevel >= seqState);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seqState <= SEQ_POR;
            hold     <= `RGL_HOLD_CYCLES;
        end else if (take) begin
            seqState <= reqLevel;
            hold     <= `RGL_HOLD_CYCLES;
        end else if (seqState != SEQ_IDLE) begin
            if (hold == `RGL_HOLD_ZERO) begin
                seqState <= SEQ_IDLE;
            end else begin
                hold <= hold - 5'h01;
            end
        end
    end

    assign porResetOut = (seqState == SEQ_POR);
    assign hwResetOut  = (seqState == SEQ_HW);
    assign swResetOut  = (seqState == SEQ_SW);

    // cold boot after por or hw
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            coldBootStart <= 1'b0;
        end else begin
            coldBootStart <= (seqState == SEQ_POR || seqState == SEQ_HW) &&
                             (hold == `RGL_HOLD_ZERO) && !take;
        end
    end

    // set wins over write-one clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cause <= `RGL_CAUSE_RESET;
        end else begin
            cause <= (cause & ~((wrEn && paddr == `RGL_OFS_CAUSE) ? pwdata[3:0]
                                                                  : `RGL_CAUSE_ZERO))
                   | {1'b0,
                      take && reqLevel == SEQ_SW,
                      take && reqLevel == SEQ_HW,
                      take && reqLevel == SEQ_POR};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register groups by reset level

    assign clrPor = !reset_n || (take && reqLevel == SEQ_POR);
    assign clrHw  = clrPor || (take && reqLevel == SEQ_HW);
    assign clrAll = clrHw || (take && reqLevel == SEQ_SW);

    always_ff @(posedge clk) begin
        if (clrPor) begin
            delayFactor   <= `RGL_FACTOR_ZERO;
            gpioPolarity  <= 1'b0;
            referenceTrim <= `RGL_ZERO16;
            radioTrim     <= `RGL_ZERO16;
        end else if (wrEn) begin
            unique case (paddr)
                `RGL_OFS_LPT:       delayFactor   <= pwdata[`RGL_FACTOR_MSB:0];
                `RGL_OFS_PIN:       gpioPolarity  <= pwdata[`RGL_POL_BIT];
                `RGL_OFS_REFTRIM:   referenceTrim <= pwdata[15:0];
                `RGL_OFS_RADIOTRIM: radioTrim     <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (clrHw) begin
            sysCtrl         <= `RGL_ZERO16;
            wakeTriggersHw  <= 1'b0;
            slowOscSwEnable <= 1'b0;
            otpWordCount    <= `RGL_ZERO16;
            exchangeMemMap  <= 2'h0;
            debugFreezeEn   <= 1'b0;
        end else if (wrEn) begin
            unique case (paddr)
                `RGL_OFS_SYSCTRL: sysCtrl <= pwdata[15:0] & `RGL_SYSCTRL_WMASK;
                `RGL_OFS_PMU: begin
                    wakeTriggersHw  <= pwdata[`RGL_WAKE_BIT];
                    slowOscSwEnable <= pwdata[`RGL_OSCEN_BIT];
                end
                `RGL_OFS_OTPWC:   otpWordCount <= pwdata[15:0];
                `RGL_OFS_GENCTRL: begin
                    exchangeMemMap <= pwdata[`RGL_EMMAP_MSB:0];
                    debugFreezeEn  <= pwdata[`RGL_DBGFRZ_BIT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (clrAll) begin
            pinSelect <= `RGL_PIN_OFF;
            scratch   <= `RGL_ZERO16;
        end else if (wrEn) begin
            unique case (paddr)
                `RGL_OFS_PIN:     pinSelect <= pwdata[`RGL_PIN_MSB:0];
                `RGL_OFS_SCRATCH: scratch   <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, data captured in the setup cycle

    always_comb begin
        rdValue = `RGL_ZERO32;
        unique case (paddr)
            `RGL_OFS_LPT:       rdValue[`RGL_FACTOR_MSB:0] = delayFactor;
            `RGL_OFS_PIN: begin
                rdValue[`RGL_PIN_MSB:0] = pinSelect;
                rdValue[`RGL_POL_BIT]   = gpioPolarity;
            end
            `RGL_OFS_SYSCTRL:   rdValue[15:0] = sysCtrl;
            `RGL_OFS_PMU: begin
                rdValue[`RGL_WAKE_BIT]  = wakeTriggersHw;
                rdValue[`RGL_OSCEN_BIT] = slowOscSwEnable;
            end
            `RGL_OFS_GENCTRL: begin
                rdValue[`RGL_EMMAP_MSB:0] = exchangeMemMap;
                rdValue[`RGL_DBGFRZ_BIT]  = debugFreezeEn;
            end
            `RGL_OFS_REFTRIM:   rdValue[15:0] = referenceTrim;
            `RGL_OFS_RADIOTRIM: rdValue[15:0] = radioTrim;
            `RGL_OFS_OTPWC:     rdValue[15:0] = otpWordCount;
            `RGL_OFS_SCRATCH:   rdValue[15:0] = scratch;
            `RGL_OFS_STATUS:    rdValue[4:0]  = {seqState, tif.busy, gpioActive, resetPad};
            `RGL_OFS_CAUSE:     rdValue[3:0]  = cause;
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= `RGL_ZERO32;
        end else if (psel && !penable && !pwrite) begin
            prdata <= addrMapped(paddr) ? rdValue : `RGL_ZERO32;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addrMapped(paddr);

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_por_from_timer;
        @(posedge clk) disable iff (!reset_n)
        tif.expire |=> porResetOut [*8];
    endproperty
    a_por_from_timer: assert property (p_por_from_timer)
        else $error("long press did not hold power-on reset");

    property p_hw_short;
        @(posedge clk) disable iff (!reset_n)
        padRelease && !tif.fired && !tif.expire &&
        (seqState == SEQ_IDLE || seqState == SEQ_SW) |=> hwResetOut && !porResetOut;
    endproperty
    a_hw_short: assert property (p_hw_short)
        else $error("short press did not give hardware reset");

    property p_sw_or;
        @(posedge clk) disable iff (!reset_n)
        (cpuSysResetReq || rebootWrite) && !tif.expire && !hwReq && seqState == SEQ_IDLE
        |=> swResetOut;
    endproperty
    a_sw_or: assert property (p_sw_or)
        else $error("software reset request ignored");

    property p_gpio_off;
        @(posedge clk) disable iff (!reset_n)
        (pinSelect == `RGL_PIN_OFF) |-> !gpioActive;
    endproperty
    a_gpio_off: assert property (p_gpio_off)
        else $error("gpio source active with pin zero");

    property p_force_osc;
        @(posedge clk) disable iff (!reset_n)
        (resetPad || gpioActive) |=> slowOscEnable;
    endproperty
    a_force_osc: assert property (p_force_osc)
        else $error("slow oscillator not forced on");

    property p_por_clears;
        @(posedge clk) disable iff (!reset_n)
        take && reqLevel == SEQ_POR |=> delayFactor == `RGL_FACTOR_ZERO &&
                                        referenceTrim == `RGL_ZERO16;
    endproperty
    a_por_clears: assert property (p_por_clears)
        else $error("power-on group not cleared");

    property p_sw_keeps;
        @(posedge clk) disable iff (!reset_n)
        take && reqLevel == SEQ_SW && !wrEn |=> otpWordCount == $past(otpWordCount);
    endproperty
    a_sw_keeps: assert property (p_sw_keeps)
        else $error("software reset cleared hardware group");

    property p_pin_clear;
        @(posedge clk) disable iff (!reset_n)
        take |=> pinSelect == `RGL_PIN_OFF;
    endproperty
    a_pin_clear: assert property (p_pin_clear)
        else $error("pin field survived a reset");

    property p_cold_boot;
        @(posedge clk) disable iff (!reset_n)
        ($fell(hwResetOut) || $fell(porResetOut)) && seqState == SEQ_IDLE |-> coldBootStart;
    endproperty
    a_cold_boot: assert property (p_cold_boot)
        else $error("no cold boot after hardware reset");

    c_por:  cover property (@(posedge clk) disable iff (!reset_n) tif.expire ##1 porResetOut);
    c_hw:   cover property (@(posedge clk) disable iff (!reset_n) padRelease ##1 hwResetOut);
    c_sw:   cover property (@(posedge clk) disable iff (!reset_n) cpuSysResetReq ##1 swResetOut);
    c_gpio: cover property (@(posedge clk) disable iff (!reset_n) gpioActive && !resetPad);

endmodule : rgl_reset_gen

// ---- design/rgl_params.svh ----
/*
 * Constants of the reset generator: register offsets, field positions,
 * reset values and counts.
 * Assumes it is included by bare name into the package and the modules.
 */
`ifndef RGL_PARAMS_SVH
`define RGL_PARAMS_SVH

// register byte offsets, one aligned 32-bit word each
`define RGL_OFS_LPT        8'h00
`define RGL_OFS_PIN        8'h04
`define RGL_OFS_SYSCTRL    8'h08
`define RGL_OFS_PMU        8'h0c
`define RGL_OFS_GENCTRL    8'h10
`define RGL_OFS_REFTRIM    8'h14
`define RGL_OFS_RADIOTRIM  8'h18
`define RGL_OFS_OTPWC      8'h1c
`define RGL_OFS_SCRATCH    8'h20
`define RGL_OFS_STATUS     8'h24
`define RGL_OFS_CAUSE      8'h28

// field positions
`define RGL_FACTOR_MSB     6
`define RGL_PIN_MSB        4
`define RGL_POL_BIT        8
`define RGL_REBOOT_BIT     0
`define RGL_WAKE_BIT       0
`define RGL_OSCEN_BIT      1
`define RGL_EMMAP_MSB      1
`define RGL_DBGFRZ_BIT     8
`define RGL_CAUSE_POR      0
`define RGL_CAUSE_HW       1
`define RGL_CAUSE_SW       2

// values and counts
`define RGL_ZERO16         16'h0000
`define RGL_ZERO32         32'h0000_0000
`define RGL_FACTOR_ZERO    7'h00
`define RGL_FACTOR_MAX     7'h7f
`define RGL_PIN_OFF        5'h00
`define RGL_PRESCALE_ZERO  12'h000
`define RGL_PRESCALE_MAX   12'hfff
`define RGL_HOLD_W         5
`define RGL_HOLD_CYCLES    5'h0f
`define RGL_HOLD_ZERO      5'h00
`define RGL_CAUSE_RESET    4'h8
`define RGL_CAUSE_ZERO     4'h0
`define RGL_SYSCTRL_WMASK  16'hfffe

`endif

// ---- design/rgl_pkg.sv ----
/*
 * Types shared by the reset generator modules.
 * Assumes rgl_params.svh is on the include path.
 */
`include "rgl_params.svh"

package rgl_pkg;
    // codes ordered by strength so that a plain compare ranks levels
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SW   = 2'b01,
        SEQ_HW   = 2'b10,
        SEQ_POR  = 2'b11
    } rgl_seq_t;

    typedef logic [`RGL_FACTOR_MSB:0] rgl_factor_t;
    typedef logic [`RGL_PIN_MSB:0]    rgl_pin_t;
endpackage : rgl_pkg

// ---- design/rgl_timer_if.sv ----
/*
 * Signals between the reset sequencer and the long-press timer.
 * Assumes both ends share one clock and reset.
 */
`timescale 1ns/1ps

interface rgl_timer_if;
    import rgl_pkg::*;
    logic        padActive;
    logic        gpioActive;
    logic        slowTick;
    rgl_factor_t delayFactor;
    logic        expire;
    logic        fired;
    logic        busy;
    logic        padFirst;

    modport timer (input padActive, input gpioActive, input slowTick, input delayFactor,
                   output expire, output fired, output busy, output padFirst);
    modport ctrl  (output padActive, output gpioActive, output slowTick, output delayFactor,
                   input expire, input fired, input busy, input padFirst);
endinterface : rgl_timer_if

// ---- design/rgl_long_press_timer.sv ----
/*
 * Long-press timer: counts slow oscillator ticks while any power-on
 * reset source is held, in whole steps of 4096 ticks.
 * Assumes slowTick is a one-cycle pulse per slow period on clk.
 */
`timescale 1ns/1ps

module rgl_long_press_timer
    import rgl_pkg::*;
(
    input wire logic    clk,
    input wire logic    reset_n,
    rgl_timer_if.timer  tif
);
    logic [11:0] prescale;
    rgl_factor_t step;
    logic        anySrc;
    logic        reached;

    assign anySrc  = tif.padActive | tif.gpioActive;
    assign reached = (step >= tif.delayFactor);
    assign tif.expire = anySrc & reached & ~tif.fired;

    always_ff @(posedge clk) begin
        if (!reset_n || !anySrc) begin
            prescale <= `RGL_PRESCALE_ZERO;
            step     <= `RGL_FACTOR_ZERO;
        end else if (tif.slowTick) begin
            if (prescale == `RGL_PRESCALE_MAX) begin
                prescale <= `RGL_PRESCALE_ZERO;
                if (step != `RGL_FACTOR_MAX) begin
                    step <= step + 7'h01;
                end
            end else begin
                prescale <= prescale + 12'h001;
            end
        end
    end

    // held until release, so a cleared factor cannot retrigger
    always_ff @(posedge clk) begin
        if (!reset_n || !anySrc) begin
            tif.fired <= 1'b0;
        end else if (reached) begin
            tif.fired <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tif.busy     <= 1'b0;
            tif.padFirst <= 1'b0;
        end else begin
            tif.busy <= anySrc;
            if (!tif.busy && anySrc) begin
                tif.padFirst <= tif.padActive;
            end else if (!anySrc) begin
                tif.padFirst <= 1'b0;
            end
        end
    end

    property p_release_clears;
        @(posedge clk) disable iff (!reset_n)
        !anySrc |=> (prescale == `RGL_PRESCALE_ZERO) && (step == `RGL_FACTOR_ZERO);
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("timer not cleared after release");

    property p_step_advance;
        @(posedge clk) disable iff (!reset_n)
        anySrc && tif.slowTick && (prescale == `RGL_PRESCALE_MAX) && (step != `RGL_FACTOR_MAX)
        |=> step == 7'($past(step) + 7'h01);
    endproperty
    a_step_advance: assert property (p_step_advance)
        else $error("step did not advance on prescaler wrap");

    property p_single_expire;
        @(posedge clk) disable iff (!reset_n)
        tif.expire |=> !tif.expire;
    endproperty
    a_single_expire: assert property (p_single_expire)
        else $error("expire repeated within one press");

endmodule : rgl_long_press_timer

// ---- testbench/rgl_osc_model.sv ----
/*
 * Slow RC oscillator model feeding the reset generator.
 * Assumes the enable comes from the block, synchronous to clk.
 */
`timescale 1ns/1ps

module rgl_osc_model (
    input  wire logic clk,
    input  wire logic enable,
    output logic      slowClk
);
    initial slowClk = 1'b0;
    always @(posedge clk) begin
        if (enable) begin
            slowClk <= ~slowClk;
        end
    end
endmodule : rgl_osc_model

// ---- testbench/testbench.sv ----
/*
 * Bench for the reset generator: APB tasks and reset scenarios.
 * Assumes the oscillator model drives slowClkIn.
 */
`timescale 1ns/1ps

module testbench;
    import rgl_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, resetPad, lastErr;
    logic        slowClkIn, cpuSysResetReq, wakeFromSleep, slowOscEnable, slowOscDefaultTrim;
    logic        porResetOut, hwResetOut, swResetOut, coldBootStart;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, gpioIn, q;
    logic [15:0] refTrim, radTrim, otpOut;
    logic [1:0]  emMap;
    logic        dbgFrz;
    int          num_errors = 0, n_compared = 0, n;
    wire  [3:0]  lvl = {coldBootStart, porResetOut, hwResetOut, swResetOut};

    rgl_reset_gen i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .resetPad(resetPad), .gpioIn(gpioIn), .slowClkIn(slowClkIn),
        .cpuSysResetReq(cpuSysResetReq), .wakeFromSleep(wakeFromSleep),
        .porResetOut(porResetOut), .hwResetOut(hwResetOut), .swResetOut(swResetOut),
        .coldBootStart(coldBootStart), .slowOscEnable(slowOscEnable),
        .slowOscDefaultTrim(slowOscDefaultTrim), .referenceTrim(refTrim), .radioTrim(radTrim),
        .otpWordCount(otpOut), .exchangeMemMap(emMap), .debugFreezeEn(dbgFrz));
    rgl_osc_model i_osc (.clk(clk), .enable(slowOscEnable), .slowClk(slowClkIn));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: %h vs %h", $time, m, seen, exp);
        end
    endtask : chk

    // called right after a rising edge; returns one edge after release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (k >= 20) begin
            chk(0, 1, "bus hang");
            complete_run();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask : rd

    // sampled on falling edges, away from the updates
    task automatic wait_for(input int i, input logic v, input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (lvl[i] !== v && n < lim);
        chk(lvl[i], v, "reset level");
        if (lvl[i] !== v) begin
            complete_run();
        end else begin
            @(posedge clk);
        end
    endtask : wait_for
    ////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, psel, penable, pwrite, resetPad, cpuSysResetReq, wakeFromSleep} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        gpioIn = 32'h0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        wait_for(3, 1'b1, 40);
        chk(porResetOut, 1'b0, "por ended");
        rd(8'h28, 32'h8, "supply cause");
        apb(1'b1, 8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h7f, "factor width");
        rd(8'h3c, 32'h0, "unmapped");
        chk(lastErr, 1'b1, "unmapped error");
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'h105);
        apb(1'b1, 8'h20, 32'h5a);
        apb(1'b1, 8'h14, 32'h1234);
        apb(1'b1, 8'h18, 32'h5678);
        // short pad press
        resetPad <= 1'b1;
        repeat (20) @(posedge clk);
        chk(slowOscEnable, 1'b1, "osc forced");
        chk(slowOscDefaultTrim, 1'b1, "pad trim");
        resetPad <= 1'b0;
        wait_for(1, 1'b1, 10);
        chk(porResetOut, 1'b0, "no por");
        wait_for(1, 1'b0, 40);
        rd(8'h04, 32'h100, "pin cleared");
        rd(8'h00, 32'h1, "factor kept");
        rd(8'h20, 32'h0, "scratch cleared");
        apb(1'b1, 8'h1c, 32'h33);
        apb(1'b1, 8'h10, 32'h103);
        apb(1'b1, 8'h08, 32'h1);
        wait_for(0, 1'b1, 10);
        wait_for(0, 1'b0, 40);
        cpuSysResetReq <= 1'b1;
        @(posedge clk);
        cpuSysResetReq <= 1'b0;
        wait_for(0, 1'b1, 10);
        wait_for(0, 1'b0, 40);
        rd(8'h1c, 32'h33, "otp kept");
        chk({dbgFrz, emMap}, 3'h7, "ctrl kept");
        chk(otpOut, 16'h33, "otp pins kept");
        apb(1'b1, 8'h0c, 32'h1);
        wakeFromSleep <= 1'b1;
        @(posedge clk);
        wakeFromSleep <= 1'b0;
        wait_for(1, 1'b1, 10);
        wait_for(1, 1'b0, 40);
        rd(8'h1c, 32'h0, "otp cleared");
        chk({dbgFrz, emMap}, 3'h0, "ctrl cleared");
        chk({refTrim, radTrim}, 32'h1234_5678, "trims kept");
        // active-low gpio press handed over to the pad
        gpioIn <= 32'hffff_ffff;
        apb(1'b1, 8'h04, 32'h3);
        gpioIn[3] <= 1'b0;
        repeat (100) @(posedge clk);
        chk(slowOscDefaultTrim, 1'b0, "gpio trim");
        resetPad <= 1'b1;
        repeat (100) @(posedge clk);
        gpioIn[3] <= 1'b1;
        wait_for(2, 1'b1, 8300);
        chk(n > 7980 && n < 8010, 1'b1, "press length");
        resetPad <= 1'b0;
        wait_for(2, 1'b0, 40);
        rd(8'h00, 32'h0, "factor cleared");
        chk({refTrim, radTrim}, 32'h0, "trims cleared");
        rd(8'h28, 32'hf, "all causes");
        complete_run();
    end
endmodule : testbench
